/* verilog/acr_ctrl.sv */
// Behaviour
// - codes 00000..01111 connect port pin channels 0 to 15
// - 10000 temp, 10001 regulator, 10010 supply, 10011 ground, rest open
// - gain bit selects unity or half gain
// - byte mode converts only eight most significant bits, fewer SAR cycles
// - byte mode forces two low bits zero, low byte reads zero except in twelve-bit mode
// - twelve-bit set is four 10-bit conversions at different reference levels
// - each conversion of a set uses different DAC element arrangement
// - twelve-bit result is sum of four results, at most 4092
// - burst count multiple of four accumulates all conversions
// - any normal start source starts a set
// - track-once set tracks only before first conversion of a set
// - track-once clear tracks before each conversion
// - buffer control bit 0 enables common-mode buffer
`timescale 1ns/1ps
`include "acr_ctrl_regs.svh"

module acr_ctrl #(
    parameter int          ACC_W     = 16,
    parameter logic [15:0] TRACK_CYC = 16'(`ACR_TRACK_CYC)
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    input  wire logic                 ce,
    input  wire logic [7:0]           sfr_addr,
    input  wire logic                 sfr_wr,
    input  wire logic [7:0]           sfr_wdata,
    output logic [7:0]                sfr_rdata,
    input  wire logic [4:0]           input_select_field,
    input  wire logic                 gain_select_bit,
    input  wire logic                 byte_mode_enable,
    input  wire logic                 twelve_bit_enable,
    input  wire logic                 burst_mode_enable,
    input  wire logic                 track_once_select,
    input  wire logic [6:0]           burst_repeat,
    input  wire logic                 conv_start,
    output logic                      busy,
    output acr_pkg::acr_mux_t         mux_ctl,
    output acr_pkg::acr_sar_req_t     sar_req,
    input  wire logic                 sar_done,
    input  wire logic [9:0]           sar_data,
    output logic                      common_mode_buffer_enable,
    output logic [7:0]                result_high_byte,
    output logic [7:0]                result_low_byte,
    output logic                      result_valid
);
    import acr_pkg::*;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // selector code to switch controls
    function automatic acr_mux_t mux_decode(input logic [4:0] code);
        acr_mux_t m;
        m = '0;
        if (!code[4]) begin
            m.pins = 16'h0001 << code[3:0];
        end
        m.temp = (code == `ACR_SEL_TEMP);
        m.ldo  = (code == `ACR_SEL_LDO);
        m.vdd  = (code == `ACR_SEL_VDD);
        m.gnd  = (code == `ACR_SEL_GND);
        return m;
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    acr_state_t       state_reg, state_next;
    acr_cfg_t         cfg_reg;
    acr_mux_t         mux_reg;
    logic [7:0]       buf_ctrl_reg;
    logic [ACC_W-1:0] acc_reg;
    logic [6:0]       idx_reg;
    logic [15:0]      trk_cnt_reg;
    logic             start_reg;
    logic [15:0]      result_reg;
    logic             valid_reg;

    // ------------------------------------------------------------
    // decode and selection
    // ------------------------------------------------------------
    wire logic        buf_hit   = (sfr_addr == `ACR_BUF_CTRL_ADDR);
    wire logic        in_idle   = (state_reg == ST_IDLE);
    wire logic        in_track  = (state_reg == ST_TRACK);
    wire logic        in_conv   = (state_reg == ST_CONV);
    wire logic        in_done   = (state_reg == ST_DONE);
    wire logic        take      = in_idle && conv_start;
    wire logic [6:0]  rep_mult  = burst_repeat & 7'h7c;
    wire logic [6:0]  n_conv    = !cfg_reg.twelve ? 7'h01 :
                                  (cfg_reg.repeat_cnt < `ACR_SET_SIZE) ? `ACR_SET_SIZE : cfg_reg.repeat_cnt;
    wire logic        last_conv = (idx_reg + 7'h01 == n_conv);
    wire logic        trk_end   = (trk_cnt_reg + 16'h0001 >= TRACK_CYC);
    wire logic [9:0]  sample    = cfg_reg.byte_mode ? {sar_data[9:2], 2'b00} : sar_data;
    wire logic [ACC_W-1:0] acc_sum = acc_reg + ACC_W'(sample);

    // register read, reserved bits read zero
    assign sfr_rdata = buf_hit ? {7'h00, buf_ctrl_reg[`ACR_BUF_EN_BIT]} : 8'h00;
    assign common_mode_buffer_enable = buf_ctrl_reg[`ACR_BUF_EN_BIT];
    assign busy = !in_idle;
    assign mux_ctl = mux_reg;
    assign sar_req.track     = in_track;
    assign sar_req.start     = start_reg;
    assign sar_req.dem_phase = idx_reg[1:0];
    assign sar_req.byte_mode = cfg_reg.byte_mode;
    assign sar_req.gain_half = cfg_reg.gain_half;
    assign result_high_byte  = result_reg[15:8];
    assign result_low_byte   = result_reg[7:0];
    assign result_valid      = valid_reg;

    // next state
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:  if (take) state_next = ST_TRACK;
            ST_TRACK: if (trk_end) state_next = ST_CONV;
            ST_CONV: begin
                if (sar_done) begin
                    if (last_conv) state_next = ST_DONE;
                    else if (!(cfg_reg.twelve && cfg_reg.track_once)) state_next = ST_TRACK;
                    else state_next = ST_CONV;
                end
            end
            ST_DONE:  state_next = ST_IDLE;
            default:  state_next = ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // buffer control register, only bit 0 writable
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            buf_ctrl_reg <= `ACR_BUF_CTRL_RESET;
        end else if (ce && sfr_wr && buf_hit) begin
            buf_ctrl_reg <= {7'h00, sfr_wdata[`ACR_BUF_EN_BIT]};
        end
    end

    // settings capture at start
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= '0;
            mux_reg <= '0;
        end else if (ce && take) begin
            cfg_reg <= '{input_select_field, gain_select_bit, byte_mode_enable,
                         twelve_bit_enable && burst_mode_enable, track_once_select, rep_mult};
            mux_reg <= mux_decode(input_select_field);
        end
    end

    // sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg   <= ST_IDLE;
            idx_reg     <= 7'h00;
            trk_cnt_reg <= 16'h0000;
            acc_reg     <= '0;
            start_reg   <= 1'b0;
        end else if (ce) begin
            state_reg   <= state_next;
            start_reg   <= (in_track && trk_end) || (in_conv && sar_done && state_next == ST_CONV);
            trk_cnt_reg <= in_track ? trk_cnt_reg + 16'h0001 : 16'h0000;
            if (take) begin
                idx_reg <= 7'h00;
                acc_reg <= '0;
            end else if (in_conv && sar_done) begin
                idx_reg <= idx_reg + 7'h01;
                acc_reg <= acc_sum;
            end
        end
    end

    // result word
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            result_reg <= 16'h0000;
            valid_reg  <= 1'b0;
        end else if (ce) begin
            valid_reg <= in_done;
            if (in_done) begin
                if (cfg_reg.twelve) result_reg <= 16'(acc_reg);
                else if (cfg_reg.byte_mode) result_reg <= {acc_reg[9:2], 8'h00};
                else result_reg <= {6'h00, acc_reg[9:0]};
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_pin_sel;
        busy && !cfg_reg.sel[4] |-> mux_ctl.pins == (16'h0001 << cfg_reg.sel[3:0]) && !mux_ctl.temp && !mux_ctl.gnd;
    endproperty
    a_pin_sel: assert property (p_pin_sel) else $error("pin channel decode wrong");

    property p_int_sel;
        busy && cfg_reg.sel >= 5'h14 |-> mux_ctl == '0;
    endproperty
    a_int_sel: assert property (p_int_sel) else $error("unused code connected something");

    property p_gain;
        ce && take |=> sar_req.gain_half == $past(gain_select_bit) && sar_req.byte_mode == $past(byte_mode_enable);
    endproperty
    a_gain: assert property (p_gain) else $error("gain or byte mode not applied");

    property p_byte_low;
        result_valid && !cfg_reg.twelve && cfg_reg.byte_mode |-> result_low_byte == 8'h00;
    endproperty
    a_byte_low: assert property (p_byte_low) else $error("byte mode low byte not zero");

    property p_dem;
        ce && in_conv && sar_done && !last_conv |=> sar_req.dem_phase == $past(sar_req.dem_phase) + 2'h1;
    endproperty
    a_dem: assert property (p_dem) else $error("element phase did not advance");

    property p_max;
        result_valid && cfg_reg.twelve && cfg_reg.repeat_cnt <= `ACR_SET_SIZE |->
            {result_high_byte, result_low_byte} <= `ACR_MAX_SET_SUM;
    endproperty
    a_max: assert property (p_max) else $error("set sum above limit");

    property p_once;
        ce && in_conv && sar_done && !last_conv && cfg_reg.twelve && cfg_reg.track_once |=> !sar_req.track ##0 start_reg;
    endproperty
    a_once: assert property (p_once) else $error("tracked again in track-once set");

    property p_each;
        ce && in_conv && sar_done && !last_conv && !cfg_reg.track_once |=> sar_req.track;
    endproperty
    a_each: assert property (p_each) else $error("no tracking before conversion");

    property p_hold;
        ce && busy && !in_done |=> $stable(cfg_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("settings changed mid conversion");

    property p_start;
        ce && take |=> busy && sar_req.track;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    c_twelve: cover property (result_valid && cfg_reg.twelve);
    c_byte:   cover property (result_valid && cfg_reg.byte_mode && !cfg_reg.twelve);
    c_once:   cover property (in_conv && sar_done && cfg_reg.track_once && cfg_reg.twelve && !last_conv);
    c_burst:  cover property (result_valid && cfg_reg.repeat_cnt > `ACR_SET_SIZE);

endmodule

/* common/acr_ctrl_regs.svh */
`ifndef ACR_CTRL_REGS_SVH
`define ACR_CTRL_REGS_SVH

// ------------------------------------------------------------
// register map and fields
// ------------------------------------------------------------
`define ACR_BUF_CTRL_ADDR   8'hb2
`define ACR_BUF_CTRL_RESET  8'h00
`define ACR_BUF_EN_BIT      0

// ------------------------------------------------------------
// input selector codes
// ------------------------------------------------------------
`define ACR_SEL_TEMP        5'h10
`define ACR_SEL_LDO         5'h11
`define ACR_SEL_VDD         5'h12
`define ACR_SEL_GND         5'h13

// ------------------------------------------------------------
// conversion figures
// ------------------------------------------------------------
`define ACR_SET_SIZE        7'h04
`define ACR_MAX_SET_SUM     16'h0ffc
`define ACR_CLK_PERIOD_NS   8
`define ACR_TRACK_NS        1500
`define ACR_TRACK_CYC       ((`ACR_TRACK_NS + `ACR_CLK_PERIOD_NS - 1) / `ACR_CLK_PERIOD_NS)

`endif

/* common/acr_pkg.sv */
package acr_pkg;

    // settings captured when a start is taken in idle, held for the whole set
    typedef struct packed {
        logic [4:0] sel;
        logic       gain_half;
        logic       byte_mode;
        logic       twelve;
        logic       track_once;
        logic [6:0] repeat_cnt;
    } acr_cfg_t;

    // analog multiplexer switch controls
    typedef struct packed {
        logic [15:0] pins;
        logic        temp;
        logic        ldo;
        logic        vdd;
        logic        gnd;
    } acr_mux_t;

    // requests to the converter core
    typedef struct packed {
        logic       track;
        logic       start;
        logic [1:0] dem_phase;
        logic       byte_mode;
        logic       gain_half;
    } acr_sar_req_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_TRACK = 4'b0010,
        ST_CONV  = 4'b0100,
        ST_DONE  = 4'b1000
    } acr_state_t;

endpackage

/* bench/acr_sar_model.sv */
`timescale 1ns/1ps
// converter core stand-in: answers each start after a short or long delay
module acr_sar_model (
    input  wire logic         clk,
    input  wire logic         reset,
    input  acr_pkg::acr_sar_req_t sar_req,
    input  wire logic         slow,
    input  wire logic         vary,
    input  wire logic [9:0]   base,
    output logic              sar_done,
    output logic [9:0]        sar_data,
    output logic [7:0]        trk_cnt
);
    import acr_pkg::*;
    logic [3:0] cnt_reg;
    logic       run_reg;
    logic       trk_d_reg;
    // ------------------------------------------------------------
    // conversion timing and track counting
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {cnt_reg, run_reg, trk_d_reg, sar_done, sar_data, trk_cnt} <= '0;
        end else begin
            trk_d_reg <= sar_req.track;
            if (sar_req.track && !trk_d_reg)
                trk_cnt <= trk_cnt + 8'h01;
            sar_done <= 1'b0;
            if (sar_done)
                sar_data <= ~sar_data; // data gone after done
            if (sar_req.start) begin
                run_reg <= 1'b1;
                cnt_reg <= slow ? 4'h6 : 4'h1;
            end else if (run_reg && cnt_reg == 4'h0) begin
                run_reg  <= 1'b0;
                sar_done <= 1'b1;
                // sample differs per element arrangement
                sar_data <= base - (vary ? 10'(sar_req.dem_phase) : 10'h000);
            end else if (run_reg) begin
                cnt_reg <= cnt_reg - 4'h1;
            end
        end
    end
endmodule

/* bench/tb.sv */
`timescale 1ns/1ps
module tb;
    import acr_pkg::*;
    typedef struct packed {
        logic [4:0]  sel;
        logic        gain;
        logic        bmode;
        logic [19:0] mux;
        logic [15:0] res;
    } acr_row_t;
    logic clk, reset, sfr_wr, conv_start, busy, sar_done, cmbe, rv, slow, vary;
    logic gain, bmode, twelve, burst, once, ce;
    logic [4:0]  sel;
    logic [6:0]  rep;
    logic [7:0]  addr, wdata, rdata, hi, lo, trk;
    logic [9:0]  base, sar_data;
    acr_mux_t     mux;
    acr_sar_req_t req;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;
    acr_row_t rows [8] = '{
        '{5'h00, 1'b0, 1'b0, 20'h0_0010, 16'h02a7}, '{5'h0f, 1'b1, 1'b0, 20'h8_0000, 16'h02a7},
        '{5'h10, 1'b0, 1'b1, 20'h0_0008, 16'ha900}, '{5'h11, 1'b1, 1'b1, 20'h0_0004, 16'ha900},
        '{5'h12, 1'b0, 1'b0, 20'h0_0002, 16'h02a7}, '{5'h13, 1'b1, 1'b0, 20'h0_0001, 16'h02a7},
        '{5'h14, 1'b0, 1'b1, 20'h0_0000, 16'ha900}, '{5'h1f, 1'b1, 1'b1, 20'h0_0000, 16'ha900}};

    acr_ctrl #(.TRACK_CYC(16'h0003)) u_dut (.clk(clk), .reset(reset), .ce(ce), .sfr_addr(addr),
        .sfr_wr(sfr_wr), .sfr_wdata(wdata), .sfr_rdata(rdata), .input_select_field(sel),
        .gain_select_bit(gain), .byte_mode_enable(bmode), .twelve_bit_enable(twelve),
        .burst_mode_enable(burst), .track_once_select(once), .burst_repeat(rep),
        .conv_start(conv_start), .busy(busy), .mux_ctl(mux), .sar_req(req), .sar_done(sar_done),
        .sar_data(sar_data), .common_mode_buffer_enable(cmbe), .result_high_byte(hi),
        .result_low_byte(lo), .result_valid(rv));
    acr_sar_model u_sar (.clk(clk), .reset(reset), .sar_req(req), .slow(slow), .vary(vary),
        .base(base), .sar_done(sar_done), .sar_data(sar_data), .trk_cnt(trk));

    // ------------------------------------------------------------
    // clock, timeout and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end
    task conclude;
        if (fails == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string nm, input logic [19:0] s, input logic [19:0] e);
        num_checks++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) {addr, wdata, sfr_wr} = {a, d, 1'b1};
        @(negedge clk) sfr_wr = 1'b0;
    endtask
    // one start; poke changes settings and pulses start again while busy
    task conv(input logic [15:0] e, input logic [7:0] et, input logic poke);
        logic [7:0] t0;
        int n;
        t0 = trk;
        @(negedge clk) conv_start = 1'b1;
        @(negedge clk) conv_start = 1'b0;
        chk("busy", 20'(busy), 20'h0_0001);
        if (poke) begin
            repeat (3) @(negedge clk);
            {sel, gain} = {~sel, ~gain};
            conv_start = 1'b1;
            @(negedge clk) conv_start = 1'b0;
        end
        n = 0;
        while (rv !== 1'b1 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        chk("result_valid", 20'(rv), 20'h0_0001);
        chk("result", 20'({hi, lo}), 20'(e));
        chk("tracks", 20'(8'(trk - t0)), 20'(et));
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {reset, sfr_wr, conv_start, sel, gain, bmode, twelve, burst, once, slow, vary} = '0;
        {rep, addr, wdata, base} = {7'h00, 8'hb2, 8'h00, 10'h2a7};
        ce = 1'b1;
        reset = 1'b1;
        repeat (10) @(posedge clk);
        @(negedge clk) reset = 1'b0;
        chk("rdata", 20'(rdata), 20'h0_0000);
        wr(8'hb2, 8'hff);
        chk("rdata", 20'(rdata), 20'h0_0001);
        chk("buffer", 20'(cmbe), 20'h0_0001);
        wr(8'hb3, 8'h00);
        chk("rdata_unmapped", 20'(rdata), 20'h0_0000);
        addr = 8'hb2;
        #1 chk("rdata", 20'(rdata), 20'h0_0001);
        wr(8'hb2, 8'h00);
        chk("buffer", 20'(cmbe), 20'h0_0000);
        // clock enable low: a write must not land
        ce = 1'b0;
        wr(8'hb2, 8'h01);
        chk("buffer_frozen", 20'(cmbe), 20'h0_0000);
        ce = 1'b1;
        foreach (rows[i]) begin
            {sel, gain, bmode} = {rows[i].sel, rows[i].gain, rows[i].bmode};
            conv(rows[i].res, 8'h01, 1'b0);
            chk("mux", mux, rows[i].mux);
            chk("gain", 20'(req.gain_half), 20'(gain));
            chk("byte_mode", 20'(req.byte_mode), 20'(bmode));
        end
        // twelve-bit sets, software enables burst as well
        {sel, gain, bmode, twelve, burst, rep, base} = {5'h00, 2'b00, 2'b11, 7'h04, 10'h3ff};
        conv(16'h0ffc, 8'h04, 1'b0);
        {once, slow, rep} = {2'b11, 7'h04};
        conv(16'h0ffc, 8'h01, 1'b0);
        bmode = 1'b1;
        conv(16'h0ff0, 8'h01, 1'b0);
        {bmode, once, slow, vary, rep, base} = {4'b0001, 7'h08, 10'h100};
        conv(16'h07f4, 8'h08, 1'b1);
        chk("mux_held", mux, 20'h0_0010);
        chk("gain_held", 20'(req.gain_half), 20'h0_0000);
        // reset in mid-conversion
        {sel, gain, vary, rep, base} = {5'h00, 2'b00, 7'h04, 10'h3ff};
        @(negedge clk) conv_start = 1'b1;
        @(negedge clk) conv_start = 1'b0;
        repeat (4) @(negedge clk);
        reset = 1'b1;
        @(negedge clk);
        chk("busy", 20'(busy), 20'h0_0000);
        chk("result", 20'({hi, lo}), 20'h0_0000);
        reset = 1'b0;
        conv(16'h0ffc, 8'h04, 1'b0);
        conclude();
    end
endmodule
